// [pcs_count_bank.sv]
/*
 * Package of shared constants for the pulse counter sampling scheduler,
 * and the pulse counter bank with atomic capture-and-clear.
 * Assumes pulse inputs are one-cycle pulses synchronous to clk.
 */
`timescale 1ns/1ns

package pcs_pkg;
	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int NUM_TABLES = 3;
	localparam int NUM_MODS = 4;
	localparam int CH_PER_MOD = 4;
	localparam int NUM_CH = NUM_MODS * CH_PER_MOD;
	localparam int CNT_W = 16;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 100000000;
	localparam real TICK_S = 0.1;
	localparam real MOD_SERVICE_MS = 0.6;
	localparam int TICK_CYCLES = int'(TICK_S * CLK_HZ);
	localparam int MOD_CYCLES = int'(MOD_SERVICE_MS * CLK_HZ / 1000.0);
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
endpackage

module pcs_count_bank (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Pulse inputs and channel enables
	input wire logic [pcs_pkg::NUM_CH-1:0] pulseIn,
	input wire logic [pcs_pkg::NUM_CH-1:0] chanActive,
	// One-hot module capture strobe
	input wire logic [pcs_pkg::NUM_MODS-1:0] captureMod,
	// Captured counts, channel c at bits c*CNT_W
	output logic [pcs_pkg::NUM_CH*pcs_pkg::CNT_W-1:0] snapCount
);
	genvar c;
	generate
		for (c = 0; c < pcs_pkg::NUM_CH; c++) begin : gCh
			logic [pcs_pkg::CNT_W-1:0] cnt_q;
			logic grab;
			logic hit;
			assign grab = captureMod[c / pcs_pkg::CH_PER_MOD];
			assign hit = pulseIn[c] & chanActive[c];
			// atomic grab: a pulse in the capture cycle starts the new interval
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					cnt_q <= pcs_pkg::CNT_ZERO;
				end else if (grab) begin
					cnt_q <= hit ? pcs_pkg::CNT_ONE : pcs_pkg::CNT_ZERO;
				end else if (hit) begin
					cnt_q <= cnt_q + pcs_pkg::CNT_ONE;
				end
			end
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					snapCount[c*pcs_pkg::CNT_W +: pcs_pkg::CNT_W] <= pcs_pkg::CNT_ZERO;
				end else if (grab) begin
					snapCount[c*pcs_pkg::CNT_W +: pcs_pkg::CNT_W] <=
						chanActive[c] ? cnt_q : pcs_pkg::CNT_ZERO;
				end
			end
		end
	endgenerate
endmodule // pcs_count_bank

// [pcs_scheduler.sv]
/*
 * Pulse counter sampling scheduler: 0.1 s tick, table priority, module
 * order, 0.6 ms per module service, overrun flag and sample substitution.
 * Assumes the table sequencer reports which tables are due, which are still
 * running, and which modules each table references.
 */
// Contract
// - Each execution of a table with a pulse instruction reads then clears its counters.
// - Tables are checked for being due once every tenth of a second.
// - Active channels of referenced modules are captured before the table starts.
// - A delayed table has its capture deferred to the next interval, never taken late.
// - Every execution overrun lights the decimal point under the display colon.
// - When configured, a count captured over an overrun is replaced by the previous count.
// - Simultaneously due tables are served from table one downward.
// - Within a table modules are served in ascending order, one through four.
// - Each module capture takes about 0.6 ms, offsetting the next module.

`timescale 1ns/1ns

module pcs_scheduler #(
	parameter int TickCycles = pcs_pkg::TICK_CYCLES,
	parameter int ModCycles = pcs_pkg::MOD_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Sensor pulses and channel enables
	input wire logic [pcs_pkg::NUM_CH-1:0] pulseIn,
	input wire logic [pcs_pkg::NUM_CH-1:0] chanActive,
	// Table sequencer status; due and running sampled on the tick, module masks also read at table selection
	input wire logic [pcs_pkg::NUM_TABLES-1:0] tableDue,
	input wire logic [pcs_pkg::NUM_TABLES-1:0] tableRunning,
	input wire logic [pcs_pkg::NUM_TABLES*pcs_pkg::NUM_MODS-1:0] tableModMask,
	// Per-module discard-on-overrun configuration
	input wire logic [pcs_pkg::NUM_MODS-1:0] discardOnOverrun,
	// Display overrun point
	input wire logic overrunAck,
	output logic overrunDp,
	// Scheduler tick and table start
	output logic schedTick,
	output logic tableStart,
	output logic [1:0] tableStartId,
	// Samples
	output logic sampleValid,
	output logic [1:0] sampleMod,
	output logic sampleOverrun,
	output logic [pcs_pkg::NUM_CH*pcs_pkg::CNT_W-1:0] sampleCount
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [1:0] lowestIdx(input logic [3:0] m);
		lowestIdx = 2'h0;
		for (int i = pcs_pkg::NUM_MODS - 1; i >= 0; i--) begin
			if (m[i]) begin
				lowestIdx = 2'(i);
			end
		end
	endfunction

	typedef enum logic [2:0] {
		S_IDLE,
		S_SELECT,
		S_CAPTURE,
		S_WAIT,
		S_START
	} pcs_state_e;

	localparam int MOD_SPAN = pcs_pkg::CH_PER_MOD * pcs_pkg::CNT_W;
	localparam logic [31:0] TICK_LAST = 32'(TickCycles - 1);
	localparam logic [31:0] MOD_LAST = 32'(ModCycles - 1);

	pcs_state_e state_q;
	logic [31:0] tickCnt_q;
	logic [31:0] waitCnt_q;
	logic [pcs_pkg::NUM_TABLES-1:0] pend_q;
	logic [pcs_pkg::NUM_TABLES-1:0] pendClr;
	logic [pcs_pkg::NUM_TABLES-1:0] ovrTables;
	logic [1:0] curTable_q;
	logic [1:0] curMod_q;
	logic [pcs_pkg::NUM_MODS-1:0] modLeft_q;
	logic [pcs_pkg::NUM_MODS-1:0] modOvr_q;
	logic [pcs_pkg::NUM_MODS-1:0] ovrMods;
	logic [pcs_pkg::NUM_MODS-1:0] captureMod;
	logic latch_q;
	logic [pcs_pkg::NUM_CH*pcs_pkg::CNT_W-1:0] snapCount;

	// ------------------------------------------------------------
	// Tick divider
	// ------------------------------------------------------------
	// tenth-second tick
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tickCnt_q <= 32'h00000000;
		end else if (tickCnt_q == TICK_LAST) begin
			tickCnt_q <= 32'h00000000;
		end else begin
			tickCnt_q <= tickCnt_q + 32'h00000001;
		end
	end
	assign schedTick = (tickCnt_q == TICK_LAST);

	// ------------------------------------------------------------
	// Due tables and overruns
	// ------------------------------------------------------------
	// running table is an overrun and is not queued
	assign ovrTables = schedTick ? (tableDue & tableRunning) : 3'h0;
	assign pendClr = (state_q == S_START) ? 3'(1 << curTable_q) : 3'h0;

	always_comb begin
		ovrMods = 4'h0;
		for (int t = 0; t < pcs_pkg::NUM_TABLES; t++) begin
			if (ovrTables[t]) begin
				ovrMods = ovrMods | tableModMask[t*pcs_pkg::NUM_MODS +: pcs_pkg::NUM_MODS];
			end
		end
	end

	// queue due tables; new demand wins over clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pend_q <= 3'h0;
		end else begin
			pend_q <= (pend_q & ~pendClr) | (schedTick ? (tableDue & ~tableRunning) : 3'h0);
		end
	end

	// sticky display point, set wins over ack
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			overrunDp <= 1'b0;
		end else if (|ovrTables) begin
			overrunDp <= 1'b1;
		end else if (overrunAck) begin
			overrunDp <= 1'b0;
		end
	end

	// mark modules whose next sample spans an overrun
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			modOvr_q <= 4'h0;
		end else begin
			modOvr_q <= (modOvr_q & ~captureMod) | ovrMods;
		end
	end

	// ------------------------------------------------------------
	// Service sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= S_IDLE;
			curTable_q <= 2'h0;
			curMod_q <= 2'h0;
			modLeft_q <= 4'h0;
			waitCnt_q <= 32'h00000000;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (|pend_q) begin
						curTable_q <= lowestIdx({1'b0, pend_q});
						modLeft_q <= tableModMask[lowestIdx({1'b0, pend_q})*pcs_pkg::NUM_MODS
							+: pcs_pkg::NUM_MODS];
						state_q <= S_SELECT;
					end
				end
				S_SELECT: begin
					if (modLeft_q == 4'h0) begin
						state_q <= S_START;
					end else begin
						curMod_q <= lowestIdx(modLeft_q);
						state_q <= S_CAPTURE;
					end
				end
				S_CAPTURE: begin
					modLeft_q <= modLeft_q & ~captureMod;
					waitCnt_q <= 32'h00000000;
					state_q <= S_WAIT;
				end
				S_WAIT: begin
					if (waitCnt_q >= MOD_LAST) begin
						state_q <= S_SELECT;
					end else begin
						waitCnt_q <= waitCnt_q + 32'h00000001;
					end
				end
				S_START: begin
					state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// capture strobe for the module being served
	assign captureMod = (state_q == S_CAPTURE) ? 4'(1 << curMod_q) : 4'h0;
	// table released only after its modules are captured
	assign tableStart = (state_q == S_START);
	assign tableStartId = curTable_q;

	pcs_count_bank uBank (
		.clk(clk),
		.sys_rst(sys_rst),
		.pulseIn(pulseIn),
		.chanActive(chanActive),
		.captureMod(captureMod),
		.snapCount(snapCount)
	);

	// ------------------------------------------------------------
	// Sample output
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			latch_q <= 1'b0;
			sampleValid <= 1'b0;
			sampleMod <= 2'h0;
			sampleOverrun <= 1'b0;
		end else begin
			latch_q <= (state_q == S_CAPTURE);
			sampleValid <= latch_q;
			if (state_q == S_CAPTURE) begin
				sampleMod <= curMod_q;
				sampleOverrun <= modOvr_q[curMod_q];
			end
		end
	end

	// keep the previous count when the sample spans an overrun and discardOnOverrun is set for its module
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sampleCount <= '0;
		end else if (latch_q && !(sampleOverrun && discardOnOverrun[sampleMod])) begin
			sampleCount[sampleMod*MOD_SPAN +: MOD_SPAN] <= snapCount[sampleMod*MOD_SPAN +: MOD_SPAN];
		end
	end
endmodule // pcs_scheduler

// [pcs_pulse_src.sv]
/*
 * Pulse sensor model: one pulse on each requested channel per cycle.
 * Assumes requests change just after a rising clk edge.
 */
`timescale 1ns/1ns
module pcs_pulse_src (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Request and sensor pulses
	input wire logic [15:0] fireReq,
	output logic [15:0] pulseOut
);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pulseOut <= 16'h0000;
		end else begin
			pulseOut <= fireReq;
		end
	end
endmodule // pcs_pulse_src

// [pcs_scheduler_props.sv]
/*
 * Port checker for pcs_scheduler, bound at the foot.
 * Assumes one clock domain and an idle scheduler at each due tick.
 */
`timescale 1ns/1ns
module pcs_scheduler_chk #(
	parameter int TickCycles = 50,
	parameter int ModCycles = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Table status and overrun acknowledge
	input wire logic [2:0] tableDue,
	input wire logic [2:0] tableRunning,
	input wire logic [11:0] tableModMask,
	input wire logic overrunAck,
	// Outputs
	input wire logic overrunDp,
	input wire logic schedTick,
	input wire logic tableStart,
	input wire logic [1:0] tableStartId,
	input wire logic sampleValid,
	input wire logic [1:0] sampleMod,
	input wire logic sampleOverrun
);
	int tickCnt_q;
	int gap_q;
	logic haveMod_q, haveId_q;
	logic [1:0] lastMod_q, lastId_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst || schedTick) tickCnt_q <= 0;
		else tickCnt_q <= tickCnt_q + 1;
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) gap_q <= 1000;
		else gap_q <= sampleValid ? 0 : gap_q + 1;
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst || tableStart) haveMod_q <= 1'b0;
		else if (sampleValid) haveMod_q <= 1'b1;
		if (sys_rst) lastMod_q <= 2'h0;
		else if (sampleValid) lastMod_q <= sampleMod;
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst || schedTick) haveId_q <= 1'b0;
		else if (tableStart) haveId_q <= 1'b1;
		if (sys_rst) lastId_q <= 2'h0;
		else if (tableStart) lastId_q <= tableStartId;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_tick_period: assert property (schedTick |-> tickCnt_q == TickCycles - 1)
		else $error("tick spacing wrong");
	a_tick_bound: assert property (tickCnt_q < TickCycles)
		else $error("tick missing");
	a_sample_gap: assert property (sampleValid |-> gap_q >= ModCycles)
		else $error("module samples too close");
	a_mod_order: assert property (sampleValid && haveMod_q |-> sampleMod > lastMod_q)
		else $error("module order wrong");
	a_table_order: assert property (tableStart && haveId_q |-> tableStartId > lastId_q)
		else $error("table order wrong");
	a_overrun_set: assert property (schedTick && (tableDue & tableRunning) != 3'h0 |=> overrunDp)
		else $error("overrun point not set");
	a_overrun_hold: assert property (overrunDp && !overrunAck |=> overrunDp)
		else $error("overrun point dropped");
	a_capture_first: assert property (schedTick && tableDue[0] && !tableRunning[0]
		&& tableModMask[0] |-> ##[4:6] sampleValid && sampleMod == 2'h0)
		else $error("capture not before start");
	a_valid_pulse: assert property (sampleValid |=> !sampleValid)
		else $error("sample valid too long");
	c_overrun_sample: cover property (sampleValid && sampleOverrun);
	c_second_table: cover property (tableStart && tableStartId == 2'h1);
	c_overrun_point: cover property (overrunDp && overrunAck);
endmodule // pcs_scheduler_chk

bind pcs_scheduler pcs_scheduler_chk #(.TickCycles(TickCycles), .ModCycles(ModCycles))
	i_pcs_scheduler_chk (.clk, .sys_rst, .tableDue, .tableRunning, .tableModMask, .overrunAck,
	.overrunDp, .schedTick, .tableStart, .tableStartId, .sampleValid, .sampleMod, .sampleOverrun);

// [pcs_scheduler_tb.sv]
/*
 * Testbench for pcs_scheduler with short tick and module service counts.
 * Assumes the pulse model delays each request by one cycle.
 */
`timescale 1ns/1ns
module pcs_scheduler_tb;
	localparam int Tick = 50;
	localparam int Mod = 5;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] fireReq = 16'h0000;
	logic [15:0] pulseIn;
	logic [15:0] chanActive = 16'hFFFD;
	logic [2:0] tableDue = 3'h0;
	logic [2:0] tableRunning = 3'h0;
	logic [11:0] tableModMask = 12'h001;
	logic [3:0] discardOnOverrun = 4'h0;
	logic overrunAck = 1'b0;
	logic overrunDp, schedTick, tableStart, sampleValid, sampleOverrun;
	logic [1:0] tableStartId, sampleMod;
	logic [255:0] sampleCount;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	int sent = 0;
	always #5 clk = ~clk;
	// Pulses on channel 0 as the design samples them
	always @(posedge clk) begin
		if (pulseIn[0] === 1'b1) begin
			sent++;
		end
	end
	pcs_pulse_src i_pcs_pulse_src (.clk, .sys_rst, .fireReq, .pulseOut(pulseIn));
	pcs_scheduler #(.TickCycles(Tick), .ModCycles(Mod)) i_pcs_scheduler (.clk, .sys_rst,
		.pulseIn, .chanActive, .tableDue, .tableRunning, .tableModMask, .discardOnOverrun,
		.overrunAck, .overrunDp, .schedTick, .tableStart, .tableStartId, .sampleValid,
		.sampleMod, .sampleOverrun, .sampleCount);
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (failures == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic pulses(input logic [15:0] ch, input int n);
		@(posedge clk);
		fireReq <= ch;
		repeat (n) @(posedge clk);
		fireReq <= 16'h0000;
		repeat (2) @(posedge clk);
	endtask
	task automatic run_tick(input logic [2:0] due, input logic [2:0] run);
		@(posedge clk);
		tableDue <= due;
		tableRunning <= run;
		do @(negedge clk); while (schedTick !== 1'b1);
		@(posedge clk);
		tableDue <= 3'h0;
		tableRunning <= 3'h0;
	endtask
	task automatic exp_sample(input logic [1:0] mod, input int ch, input logic [15:0] cnt);
		do @(negedge clk); while (sampleValid !== 1'b1);
		chk("sampleMod", {14'h0000, sampleMod}, {14'h0000, mod});
		chk("sampleCount", sampleCount[ch*16+:16], cnt);
	endtask
	task automatic exp_start(input logic [1:0] id);
		do @(negedge clk); while (tableStart !== 1'b1);
		chk("tableStartId", {14'h0000, tableStartId}, {14'h0000, id});
	endtask
	task automatic t_basic();
		pulses(16'h0003, 3);
		run_tick(3'h1, 3'h0);
		exp_sample(2'h0, 0, 16'h0003);
		chk("inactive", sampleCount[31:16], 16'h0000);
		chk("sampleOverrun", {15'h0000, sampleOverrun}, 16'h0000);
		exp_start(2'h0);
		run_tick(3'h1, 3'h0);
		exp_sample(2'h0, 0, 16'h0000);
		exp_start(2'h0);
	endtask
	task automatic t_order();
		@(posedge clk);
		tableModMask <= 12'h025;
		pulses(16'h0110, 2);
		run_tick(3'h3, 3'h0);
		exp_sample(2'h0, 0, 16'h0000);
		exp_sample(2'h2, 8, 16'h0002);
		exp_start(2'h0);
		exp_sample(2'h1, 4, 16'h0002);
		exp_start(2'h1);
	endtask
	task automatic t_overrun();
		@(posedge clk);
		tableModMask <= 12'h001;
		discardOnOverrun <= 4'h1;
		pulses(16'h0001, 5);
		run_tick(3'h1, 3'h0);
		exp_sample(2'h0, 0, 16'h0005);
		pulses(16'h0001, 2);
		run_tick(3'h1, 3'h1);
		repeat (20) begin
			@(negedge clk);
			chk("deferred", {15'h0000, sampleValid | tableStart}, 16'h0000);
		end
		chk("overrunDp", {15'h0000, overrunDp}, 16'h0001);
		pulses(16'h0001, 1);
		run_tick(3'h1, 3'h0);
		exp_sample(2'h0, 0, 16'h0005);
		chk("sampleOverrun", {15'h0000, sampleOverrun}, 16'h0001);
		exp_start(2'h0);
		@(posedge clk);
		overrunAck <= 1'b1;
		@(posedge clk);
		overrunAck <= 1'b0;
		@(negedge clk);
		chk("overrunAck", {15'h0000, overrunDp}, 16'h0000);
	endtask
	task automatic t_atomic();
		int base;
		logic [15:0] first;
		base = sent;
		@(posedge clk);
		discardOnOverrun <= 4'h0;
		fireReq <= 16'h0001;
		run_tick(3'h1, 3'h0);
		do @(negedge clk); while (sampleValid !== 1'b1);
		first = sampleCount[15:0];
		@(posedge clk);
		fireReq <= 16'h0000;
		run_tick(3'h1, 3'h1);
		run_tick(3'h1, 3'h0);
		do @(negedge clk); while (sampleValid !== 1'b1);
		chk("pulseTotal", first + sampleCount[15:0], 16'(sent - base));
		chk("sampleOverrun", {15'h0000, sampleOverrun}, 16'h0001);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		t_basic();
		t_order();
		t_overrun();
		t_atomic();
		finish_test();
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			finish_test();
		end
	end
endmodule // pcs_scheduler_tb
